// >>> smr_mode_ctrl.sv
// register bank and frame-synchronised mode control of the sensor sequencer
`timescale 1ns/1ps
module smr_mode_ctrl #(
    parameter int FRAME_CYCLES = smr_pkg::FRAME_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // serial configuration pins
    input wire logic spiClk,
    input wire logic spiCsN,
    input wire logic spiMosi,
    output logic spiMiso,
    output logic spiMisoOe,
    // power sequencing
    input wire logic powerReady,
    // sequencer status
    output logic seqRunning,
    output logic frameStart,
    output logic blankFrame,
    output logic syncCodeSuspect,
    // active configuration
    output logic actRolling,
    output logic actTriggered,
    output logic actSlave,
    output logic actSubsample,
    output logic actBinning,
    output logic [31:0] actWindowMask,
    output logic [47:0] actExposure,
    output logic [15:0] actGain
);
    localparam int DEPTH = 1 << smr_pkg::ADDR_W;

    smr_cfg_if cfg ();

    logic [15:0] cfgMem_q [DEPTH];
    smr_pkg::smr_state_e state_q;
    smr_pkg::smr_state_e state_d;
    logic [31:0] frameCnt_q;
    logic blankPend_q;
    logic [47:0] expStage_q;
    logic [15:0] gainStage_q;
    logic powerReadySync_q;
    logic powerReadyMeta_q;
    logic [15:0] modeReg;
    logic [31:0] maskReg;
    logic [47:0] expReg;
    logic [15:0] gainReg;
    logic running;
    logic fsNow;
    logic wrRun;
    logic wrLinesChg;
    logic linesBlank;
    logic newWindow;
    logic roiBlank;
    logic setBlank;
    logic syncWr;
    logic expDirect;

    function automatic logic [15:0] rstVal(input logic [8:0] a);
        if (a == smr_pkg::A_MODE) begin
            rstVal = smr_pkg::MODE_RST;
        end else if (a == smr_pkg::A_MASK_LO) begin
            rstVal = smr_pkg::MASK_LO_RST;
        end else if (a == smr_pkg::A_ROI0_X) begin
            rstVal = smr_pkg::ROI0_X_RST;
        end else if (a == smr_pkg::A_ROI0_YEND) begin
            rstVal = smr_pkg::ROI0_YEND_RST;
        end else begin
            rstVal = smr_pkg::ZERO_RST;
        end
    endfunction

    function automatic logic inRange(input logic [8:0] a, input logic [8:0] lo,
                                     input logic [8:0] hi);
        inRange = (a >= lo) && (a <= hi);
    endfunction

    smr_spi_slave u_spi (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .spiClk(spiClk),
        .spiCsN(spiCsN),
        .spiMosi(spiMosi),
        .spiMiso(spiMiso),
        .spiMisoOe(spiMisoOe),
        .cfg(cfg.port)
    );

    // named views of the bank
    assign modeReg = cfgMem_q[smr_pkg::A_MODE];
    assign maskReg = {cfgMem_q[smr_pkg::A_MASK_HI], cfgMem_q[smr_pkg::A_MASK_LO]};
    assign expReg = {cfgMem_q[smr_pkg::A_EXP2], cfgMem_q[smr_pkg::A_EXP1],
                     cfgMem_q[smr_pkg::A_EXP0]};
    assign gainReg = cfgMem_q[smr_pkg::A_GAIN];
    assign cfg.rdData = cfgMem_q[cfg.addr];

    assign running = (state_q == smr_pkg::ST_RUN);
    assign fsNow = running && (frameCnt_q == 32'h0);
    assign wrRun = cfg.wrEn && running;

    assign wrLinesChg = ((cfg.addr == smr_pkg::A_BLACK_LINES)
                         || (cfg.addr == smr_pkg::A_DUMMY_LINES))
                        && (cfg.wrData[smr_pkg::LINES_MSB:0]
                            != cfgMem_q[cfg.addr][smr_pkg::LINES_MSB:0]);
    assign linesBlank = wrRun && wrLinesChg && actRolling;

    assign newWindow = ((cfg.addr == smr_pkg::A_MASK_LO)
                        && ((cfg.wrData & ~cfgMem_q[smr_pkg::A_MASK_LO]) != 16'h0000))
                       || ((cfg.addr == smr_pkg::A_MASK_HI)
                        && ((cfg.wrData & ~cfgMem_q[smr_pkg::A_MASK_HI]) != 16'h0000));
    assign roiBlank = wrRun && newWindow && actRolling
                      && cfgMem_q[smr_pkg::A_SYNC_CFG][smr_pkg::B_BLANK_ROI];

    assign setBlank = linesBlank || roiBlank;

    // sync codes or word depth during a frame
    assign syncWr = wrRun && inRange(cfg.addr, smr_pkg::A_SYNC_LO, smr_pkg::A_SYNC_HI);

    // triggered global master with sync mode
    assign expDirect = modeReg[smr_pkg::B_EXP_SYNC] && actTriggered && !actSlave
                       && !actRolling;

    // enable bit starts and stops grabbing
    always_comb begin
        state_d = state_q;
        case (state_q)
            smr_pkg::ST_STANDBY: begin
                if (powerReadySync_q) begin
                    state_d = smr_pkg::ST_IDLE;
                end
            end
            smr_pkg::ST_IDLE: begin
                if (!powerReadySync_q) begin
                    state_d = smr_pkg::ST_STANDBY;
                end else if (modeReg[smr_pkg::B_SEQ_EN]) begin
                    state_d = smr_pkg::ST_RUN;
                end
            end
            smr_pkg::ST_RUN: begin
                if (!modeReg[smr_pkg::B_SEQ_EN]) begin
                    state_d = smr_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = smr_pkg::ST_STANDBY;
            end
        endcase
    end

    // power-ready pin through two flops
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            powerReadyMeta_q <= 1'b0;
            powerReadySync_q <= 1'b0;
        end else begin
            powerReadyMeta_q <= powerReady;
            powerReadySync_q <= powerReadyMeta_q;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= smr_pkg::ST_STANDBY;
            seqRunning <= 1'b0;
        end else begin
            state_q <= state_d;
            seqRunning <= (state_d == smr_pkg::ST_RUN);
        end
    end

    // window zero full frame and active at reset
    // window writes taken in any state
    // exposure and gain writes taken in any state
    // black-level words go live at once
    // test-pattern words go live at once
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < DEPTH; i++) begin
                cfgMem_q[i] <= rstVal(9'(i));
            end
        end else if (cfg.wrEn) begin
            cfgMem_q[cfg.addr] <= cfg.wrData;
        end
    end

    // frame timer restarts on every entry to running
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            frameCnt_q <= 32'h0;
        end else if (!running || frameCnt_q == 32'(FRAME_CYCLES - 1)) begin
            frameCnt_q <= 32'h0;
        end else begin
            frameCnt_q <= frameCnt_q + 32'h1;
        end
    end

    // frame start pulse follows the timer wrap
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            frameStart <= 1'b0;
        end else begin
            frameStart <= fsNow;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            blankPend_q <= 1'b0;
        end else begin
            blankPend_q <= setBlank || (blankPend_q && !fsNow && running);
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            blankFrame <= 1'b0;
        end else if (!running) begin
            blankFrame <= 1'b0;
        end else if (fsNow) begin
            blankFrame <= blankPend_q;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            syncCodeSuspect <= 1'b0;
        end else begin
            syncCodeSuspect <= syncWr || (syncCodeSuspect && !fsNow && running);
        end
    end

    // static mode fields follow only while stopped
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            actRolling <= 1'b0;
        end else if (!running) begin
            actRolling <= modeReg[smr_pkg::B_ROLLING];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            actTriggered <= 1'b0;
        end else if (!running) begin
            actTriggered <= modeReg[smr_pkg::B_TRIG] & ~modeReg[smr_pkg::B_ROLLING];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            actSlave <= 1'b0;
        end else if (!running) begin
            actSlave <= modeReg[smr_pkg::B_SLAVE] & ~modeReg[smr_pkg::B_ROLLING];
        end
    end

    // frame parameters load only at frame start
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            actSubsample <= 1'b0;
        end else if (fsNow) begin
            actSubsample <= modeReg[smr_pkg::B_SUBSAMP];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            actBinning <= 1'b0;
        end else if (fsNow) begin
            actBinning <= modeReg[smr_pkg::B_BINNING];
        end
    end

    // regions enabled by the activation masks
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            actWindowMask <= {16'h0000, smr_pkg::MASK_LO_RST};
        end else if (fsNow) begin
            actWindowMask <= maskReg;
        end
    end

    // exposure through one extra frame stage, except triggered global master with sync mode loads directly
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            expStage_q <= 48'h0;
            actExposure <= 48'h0;
        end else if (fsNow) begin
            expStage_q <= expReg;
            actExposure <= expDirect ? expReg : expStage_q;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            gainStage_q <= 16'h0000;
            actGain <= 16'h0000;
        end else if (fsNow) begin
            gainStage_q <= gainReg;
            actGain <= gainReg[smr_pkg::B_GAIN_LAT] ? gainStage_q : gainReg;
        end
    end
endmodule

// >>> smr_pkg.sv
// shared constants for the mode reconfiguration control block
package smr_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;
    localparam int SPI_BITS = 26;
    localparam int SPI_CNT_W = 5;
    // register addresses
    localparam logic [8:0] A_BLACK_CFG = 9'h080;
    localparam logic [8:0] A_SYNC_LO = 9'h081;
    localparam logic [8:0] A_SYNC_HI = 9'h087;
    localparam logic [8:0] A_TEST_LO = 9'h090;
    localparam logic [8:0] A_TEST_HI = 9'h096;
    localparam logic [8:0] A_MODE = 9'h0c0;
    localparam logic [8:0] A_MASK_LO = 9'h0c3;
    localparam logic [8:0] A_MASK_HI = 9'h0c4;
    localparam logic [8:0] A_BLACK_LINES = 9'h0c5;
    localparam logic [8:0] A_DUMMY_LINES = 9'h0c6;
    localparam logic [8:0] A_EXP0 = 9'h0c7;
    localparam logic [8:0] A_EXP1 = 9'h0c8;
    localparam logic [8:0] A_EXP2 = 9'h0c9;
    localparam logic [8:0] A_GAIN = 9'h0cc;
    localparam logic [8:0] A_SYNC_CFG = 9'h0ce;
    localparam logic [8:0] A_ROI_LO = 9'h100;
    localparam logic [8:0] A_ROI_HI = 9'h15f;
    // window 0 geometry words
    localparam logic [8:0] A_ROI0_X = 9'h100;
    localparam logic [8:0] A_ROI0_YSTART = 9'h101;
    localparam logic [8:0] A_ROI0_YEND = 9'h102;
    // field positions
    localparam int B_SEQ_EN = 0;
    localparam int B_ROLLING = 1;
    localparam int B_TRIG = 4;
    localparam int B_SLAVE = 5;
    localparam int B_EXP_SYNC = 6;
    localparam int B_SUBSAMP = 7;
    localparam int B_BINNING = 8;
    localparam int B_GAIN_LAT = 13;
    localparam int B_BLANK_ROI = 8;
    localparam int LINES_MSB = 7;
    // reset values
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [15:0] MASK_LO_RST = 16'h0001;
    localparam logic [15:0] ROI0_X_RST = 16'h4f00;
    localparam logic [15:0] ROI0_YEND_RST = 16'h13ff;
    localparam logic [15:0] ZERO_RST = 16'h0000;
    // timing
    localparam int CLK_MHZ = 25;
    localparam int FRAME_US = 20000;
    localparam int FRAME_CYC = FRAME_US * CLK_MHZ;
    // sequencer states
    typedef enum logic [2:0] {
        ST_STANDBY = 3'b001,
        ST_IDLE = 3'b010,
        ST_RUN = 3'b100
    } smr_state_e;
endpackage

// >>> smr_cfg_if.sv
// register access carrier between serial port and register bank
`timescale 1ns/1ps
interface smr_cfg_if;
    logic wrEn;
    logic [8:0] addr;
    logic [15:0] wrData;
    logic [15:0] rdData;
    modport port (output wrEn, output addr, output wrData, input rdData);
    modport bank (input wrEn, input addr, input wrData, output rdData);
endinterface

// >>> smr_spi_slave.sv
// serial configuration port: 9-bit address, write flag, 16-bit data
`timescale 1ns/1ps
module smr_spi_slave (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // serial pins
    input wire logic spiClk,
    input wire logic spiCsN,
    input wire logic spiMosi,
    output logic spiMiso,
    output logic spiMisoOe,
    // register side
    smr_cfg_if.port cfg
);
    logic [2:0] clkSync_q;
    logic [1:0] csSync_q;
    logic [1:0] mosiSync_q;
    logic [smr_pkg::SPI_CNT_W-1:0] bitCnt_q;
    logic [25:0] shift_q;
    logic isRead_q;
    logic [15:0] outShift_q;
    logic wrEn_q;
    logic [8:0] addr_q;
    logic [15:0] wrData_q;
    logic active;
    logic riseEdge;
    logic fallEdge;
    logic [25:0] shiftNext;

    // select and data pins pass two flops, clock pin three; edge detect reads only later stages
    assign active = ~csSync_q[1];
    assign riseEdge = active & clkSync_q[1] & ~clkSync_q[2];
    assign fallEdge = active & ~clkSync_q[1] & clkSync_q[2];
    assign shiftNext = {shift_q[24:0], mosiSync_q[1]};
    assign cfg.wrEn = wrEn_q;
    assign cfg.addr = addr_q;
    assign cfg.wrData = wrData_q;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            clkSync_q <= 3'h0;
            csSync_q <= 2'h3;
            mosiSync_q <= 2'h0;
        end else begin
            clkSync_q <= {clkSync_q[1:0], spiClk};
            csSync_q <= {csSync_q[0], spiCsN};
            mosiSync_q <= {mosiSync_q[0], spiMosi};
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            bitCnt_q <= 5'h00;
            shift_q <= 26'h0;
            isRead_q <= 1'b0;
            wrEn_q <= 1'b0;
            addr_q <= 9'h000;
            wrData_q <= 16'h0000;
        end else begin
            wrEn_q <= 1'b0;
            if (!active) begin
                bitCnt_q <= 5'h00;
                isRead_q <= 1'b0;
            end else if (riseEdge && bitCnt_q != 5'(smr_pkg::SPI_BITS)) begin
                shift_q <= shiftNext;
                bitCnt_q <= bitCnt_q + 5'h01;
                if (bitCnt_q == 5'h08) begin
                    addr_q <= shiftNext[8:0];
                end
                if (bitCnt_q == 5'h09) begin
                    isRead_q <= ~shiftNext[0];
                end
                if (bitCnt_q == 5'(smr_pkg::SPI_BITS - 1) && !isRead_q) begin
                    wrData_q <= shiftNext[15:0];
                    wrEn_q <= 1'b1;
                end
            end
        end
    end

    // read data leaves msb first on falling edges
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            outShift_q <= 16'h0000;
            spiMiso <= 1'b0;
            spiMisoOe <= 1'b0;
        end else begin
            spiMisoOe <= active & isRead_q;
            if (fallEdge && isRead_q) begin
                if (bitCnt_q == 5'h0a) begin
                    spiMiso <= cfg.rdData[15];
                    outShift_q <= {cfg.rdData[14:0], 1'b0};
                end else begin
                    spiMiso <= outShift_q[15];
                    outShift_q <= {outShift_q[14:0], 1'b0};
                end
            end
        end
    end
endmodule

// >>> smr_host_model.sv
// host controller model driving the serial configuration port
`timescale 1ns/1ps
module smr_host_model #(
    parameter int HALF = 6
) (
    // clock
    input wire logic sys_clk,
    // serial pins
    output logic spiClk,
    output logic spiCsN,
    output logic spiMosi,
    input wire logic spiMiso,
    input wire logic spiMisoOe
);
    initial begin
        spiClk = 1'b0;
        spiCsN = 1'b1;
        spiMosi = 1'b0;
    end
    // host sends only what the bench asks
    task automatic xfer(input logic [8:0] a, input logic w, input logic [15:0] d,
                        output logic [15:0] q);
        logic [25:0] sh;
        sh = {a, w, d};
        q = 16'h0000;
        @(posedge sys_clk);
        spiCsN <= 1'b0;
        for (int i = 25; i >= 0; i--) begin
            spiMosi <= sh[i];
            repeat (HALF) @(posedge sys_clk);
            spiClk <= 1'b1;
            if (i < 16) q = {q[14:0], spiMiso & spiMisoOe};
            repeat (HALF) @(posedge sys_clk);
            spiClk <= 1'b0;
        end
        repeat (HALF) @(posedge sys_clk);
        spiCsN <= 1'b1;
        spiMosi <= ~spiMosi;
        repeat (HALF) @(posedge sys_clk);
    endtask
endmodule

// >>> smr_mode_ctrl_assertions.sv
// port-level checks of the mode control block
`timescale 1ns/1ps
module smr_mode_ctrl_assertions #(
    parameter int FRAME_CYCLES = smr_pkg::FRAME_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // status
    input wire logic seqRunning,
    input wire logic frameStart,
    input wire logic blankFrame,
    // active configuration
    input wire logic actRolling,
    input wire logic actTriggered,
    input wire logic actSlave,
    input wire logic actSubsample,
    input wire logic actBinning,
    input wire logic [31:0] actWindowMask,
    input wire logic [47:0] actExposure,
    input wire logic [15:0] actGain
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic [31:0] gap_q;
    logic seen_q;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            gap_q <= 32'h0;
            seen_q <= 1'b0;
        end else begin
            gap_q <= frameStart ? 32'h0 : gap_q + 32'h1;
            seen_q <= seqRunning && (seen_q || frameStart);
        end
    end
    a_frame_period: assert property (
        frameStart && seen_q |-> gap_q == FRAME_CYCLES - 1) else $error("frame period wrong");
    a_first_frame: assert property (
        $rose(seqRunning) |=> frameStart) else $error("no frame after start");
    a_subbin_sync: assert property (
        seqRunning && $past(seqRunning) && !$stable({actSubsample, actBinning})
        |-> $past(frameStart) or (##[0:1] frameStart)) else $error("mode bits off frame");
    a_mask_sync: assert property (
        seqRunning && $past(seqRunning) && !$stable(actWindowMask)
        |-> $past(frameStart) or (##[0:1] frameStart)) else $error("mask off frame");
    a_gain_sync: assert property (
        seqRunning && $past(seqRunning) && !$stable(actGain)
        |-> $past(frameStart) or (##[0:1] frameStart)) else $error("gain off frame");
    a_exp_hold: assert property (
        !frameStart && !$past(frameStart) && seqRunning && $past(seqRunning)
        ##1 !frameStart |-> $stable(actExposure)) else $error("exposure off frame");
    a_blank_edge: assert property (
        $rose(blankFrame) |-> $past(frameStart) or (##[0:1] frameStart))
        else $error("blank off frame");
    a_blank_rolling: assert property (
        blankFrame |-> actRolling) else $error("blank in global mode");
    a_global_only: assert property (
        actTriggered || actSlave |-> !actRolling) else $error("trigger or slave in rolling");
endmodule
bind smr_mode_ctrl smr_mode_ctrl_assertions #(.FRAME_CYCLES(FRAME_CYCLES)) i_chk (
    .sys_clk(sys_clk), .nrst(nrst), .seqRunning(seqRunning), .frameStart(frameStart),
    .blankFrame(blankFrame), .actRolling(actRolling), .actTriggered(actTriggered),
    .actSlave(actSlave), .actSubsample(actSubsample), .actBinning(actBinning),
    .actWindowMask(actWindowMask), .actExposure(actExposure), .actGain(actGain));

// >>> smr_mode_ctrl_tb.sv
// self-checking bench of the mode control block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module smr_mode_ctrl_tb;
    localparam int FC = 2000;
    logic sys_clk, nrst, powerReady, spiClk, spiCsN, spiMosi, spiMiso, spiMisoOe;
    logic seqRunning, frameStart, blankFrame, syncCodeSuspect;
    logic actRolling, actTriggered, actSlave, actSubsample, actBinning;
    logic [31:0] actWindowMask;
    logic [47:0] actExposure;
    logic [15:0] actGain, rnd, rdv, g1, ex, wd;
    logic [8:0] wa;
    logic [8:0] ca [4];
    logic [15:0] cv [4];
    int mismatches = 0;
    int num_checks = 0;
    smr_mode_ctrl #(.FRAME_CYCLES(FC)) i_smr_mode_ctrl (.sys_clk(sys_clk), .nrst(nrst),
        .spiClk(spiClk), .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso),
        .spiMisoOe(spiMisoOe), .powerReady(powerReady), .seqRunning(seqRunning),
        .frameStart(frameStart), .blankFrame(blankFrame), .syncCodeSuspect(syncCodeSuspect),
        .actRolling(actRolling), .actTriggered(actTriggered), .actSlave(actSlave),
        .actSubsample(actSubsample), .actBinning(actBinning), .actWindowMask(actWindowMask),
        .actExposure(actExposure), .actGain(actGain));
    smr_host_model i_smr_host_model (.sys_clk(sys_clk), .spiClk(spiClk), .spiCsN(spiCsN),
        .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe));
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [2:0] mode_act(input logic [15:0] m);
        return {m[1], m[4] & ~m[1], m[5] & ~m[1]};
    endfunction
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        logic [15:0] x;
        i_smr_host_model.xfer(a, 1'b1, d, x);
    endtask
    task automatic rd(input logic [8:0] a, output logic [15:0] d);
        i_smr_host_model.xfer(a, 1'b0, 16'h0000, d);
    endtask
    task automatic wait_fs();
        int n;
        n = 0;
        while (frameStart !== 1'b1 && n < 3 * FC) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 3 * FC) mismatches++;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    task automatic give_verdict();
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        #(40 * 45 * FC);
        mismatches++;
        give_verdict();
    end
    initial begin
        nrst = 1'b0;
        powerReady = 1'b0;
        rnd = 16'h0044;
        ca = '{smr_pkg::A_MODE, smr_pkg::A_MASK_LO, smr_pkg::A_ROI0_X, smr_pkg::A_ROI0_YEND};
        cv = '{smr_pkg::MODE_RST, smr_pkg::MASK_LO_RST, smr_pkg::ROI0_X_RST,
            smr_pkg::ROI0_YEND_RST};
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        `CHK("window mask", 32'h00000001, actWindowMask)
        for (int i = 0; i < 4; i++) begin
            rd(ca[i], rdv);
            `CHK("reset value", cv[i], rdv)
        end
        // only window and gain words are written
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            wa = (i == 4) ? smr_pkg::A_GAIN : (i == 5) ? smr_pkg::A_ROI_HI :
                smr_pkg::A_ROI_LO + 9'(rnd[7:0] % 8'd96);
            wd = (i == 4) ? (rnd & 16'hdfff) : rnd;
            wr(wa, wd);
            rd(wa, rdv);
            `CHK("readback", wd, rdv)
        end
        powerReady <= 1'b1;
        repeat (8) @(posedge sys_clk);
        for (int i = 0; i < 3; i++) begin
            wd = (i == 0) ? 16'h0032 : (i == 1) ? 16'h0030 : 16'h0002;
            wr(smr_pkg::A_MODE, wd);
            `CHK("mode", mode_act(wd), {actRolling, actTriggered, actSlave})
        end
        wr(smr_pkg::A_MODE, 16'h0003);
        `CHK("running", 1'b1, seqRunning)
        wait_fs();
        rnd = lfsr(rnd);
        g1 = rnd & 16'hdfff;
        ex = lfsr(rnd);
        wr(smr_pkg::A_MODE, 16'h0183);
        wr(smr_pkg::A_MASK_LO, 16'h0003);
        wr(smr_pkg::A_GAIN, g1);
        wr(smr_pkg::A_EXP0, ex);
        `CHK("subsample binning", 2'b00, {actSubsample, actBinning})
        `CHK("window mask", 32'h00000001, actWindowMask)
        wait_fs();
        `CHK("subsample binning", 2'b11, {actSubsample, actBinning})
        `CHK("window mask", 32'h00000003, actWindowMask)
        `CHK("gain", g1, actGain)
        `CHK("exposure", 48'h0, actExposure)
        `CHK("blank", 1'b0, blankFrame)
        wr(smr_pkg::A_GAIN, ex | 16'h2000);
        wr(smr_pkg::A_SYNC_CFG, 16'h0100);
        wait_fs();
        `CHK("exposure", {32'h0, ex}, actExposure)
        `CHK("gain", g1, actGain)
        wait_fs();
        `CHK("gain", ex | 16'h2000, actGain)
        ca = '{smr_pkg::A_BLACK_LINES, smr_pkg::A_DUMMY_LINES, smr_pkg::A_MASK_LO,
            smr_pkg::A_ROI0_X};
        cv = '{16'h0010, 16'h0020, 16'h0007, 16'h1234};
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            wr(ca[i], cv[i]);
            wr(smr_pkg::A_SYNC_LO + 9'h1, rnd);
            `CHK("sync suspect", 1'b1, syncCodeSuspect)
            wait_fs();
            `CHK("blank", i != 3, blankFrame)
            `CHK("sync suspect", 1'b0, syncCodeSuspect)
            wait_fs();
            `CHK("blank", 1'b0, blankFrame)
        end
        wr(smr_pkg::A_MODE, 16'h0182);
        `CHK("running", 1'b0, seqRunning)
        // triggered global master with exposure sync: no extra frame
        wr(smr_pkg::A_MODE, 16'h01d0);
        `CHK("mode", mode_act(16'h01d0), {actRolling, actTriggered, actSlave})
        wr(smr_pkg::A_MODE, 16'h01d1);
        wait_fs();
        rnd = lfsr(rnd);
        wr(smr_pkg::A_EXP0, rnd);
        wait_fs();
        `CHK("exposure", {32'h0, rnd}, actExposure)
        wr(smr_pkg::A_MODE, 16'h01d0);
        give_verdict();
    end
endmodule
